/* File: hw/ssp_pkg.sv */
// Purpose: shared constants and types for the sync sram port conditions block
// Assumes: 100 MHz clk_in, 16-bit address, 18-bit data in two 9-bit lanes
// Notes: reset values and counts live here
package ssp_pkg;
  // ==========================================================
  // geometry
  localparam int SSP_ADDR_W = 16;
  localparam int SSP_DATA_W = 18;
  localparam int SSP_LANE_W = 9;
  localparam int SSP_LANES = 2;
  localparam int SSP_DEPTH = 65536;
  // ==========================================================
  // timing
  localparam int SSP_CLK_PERIOD_NS = 10;
  localparam int SSP_POWERUP_WAIT_MS = 1;
  localparam int SSP_POWERUP_WAIT_CYC = (SSP_POWERUP_WAIT_MS * 1000000) / SSP_CLK_PERIOD_NS;
  localparam logic [1:0] SSP_BURST_RST = 2'h0;
  localparam logic SSP_DRIVE_RST = 1'b0;
  // ==========================================================
  // port operating state
  typedef enum logic [1:0]
  {
    SSP_IDLE = 2'b00,
    SSP_READ = 2'b01,
    SSP_WRITE = 2'b11,
    SSP_SLEEP = 2'b10
  } ssp_mode_t;
endpackage : ssp_pkg

/* File: hw/ssp_sync2.sv */
// Purpose: two-flop synchroniser for a level from outside the clock domain
// Assumes: clk_in domain, synchronous active-high reset
// Notes: first stage is read only by the second stage
module ssp_sync2
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // level
  input wire logic async_in,
  output logic sync_out
);
  import ssp_pkg::*;
  typedef struct packed
  {
    logic meta;
    logic sync;
  } ssp_sync_t;
  ssp_sync_t st_ff;
  ssp_sync_t nxt_st;
  // next state
  always_comb
  begin
    nxt_st.meta = async_in;
    nxt_st.sync = st_ff.meta;
    if (sys_rst_in)
    begin
      nxt_st = '0;
    end
  end
  // state register
  always_ff @(posedge clk_in)
  begin
    st_ff <= nxt_st;
  end
  assign sync_out = st_ff.sync;
endmodule : ssp_sync2

/* File: hw/ssp_port.sv */
// Purpose: flow-through synchronous burst sram port with select decode and sleep
// Assumes: all control inputs sampled on clk_in; sleep_request and output_enable_n_in are asynchronous
// Notes: 2-bit burst counter; linear or interleaved by burst_mode_in
//
// Contract
// RQ1 - host waits one millisecond after power up before any access
// RQ2 - selected only when select_low_a low, select_high high, select_low_b low
// RQ3 - full write on global_write_n low, or gate low with both lanes low
// RQ4 - data stays high impedance after a write until a strobe or advance cycle
// RQ5 - host deselects the memory before asserting sleep_request
// RQ6 - data pins are high impedance when leaving sleep mode
module ssp_port
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // address and burst control
  input wire logic [ssp_pkg::SSP_ADDR_W-1:0] addr_in,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic burst_mode_in,
  // selects
  input wire logic select_low_a_in,
  input wire logic select_high_in,
  input wire logic select_low_b_in,
  // write enables
  input wire logic global_write_n_in,
  input wire logic byte_write_gate_n_in,
  input wire logic [ssp_pkg::SSP_LANES-1:0] lane_write_n_in,
  // output enable and sleep
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  // data pins, enable low while driving
  input wire logic [ssp_pkg::SSP_DATA_W-1:0] data_in,
  output logic [ssp_pkg::SSP_DATA_W-1:0] data_out,
  output logic data_oe_n_out,
  // status
  output logic sleeping_out
);
  import ssp_pkg::*;
  typedef struct packed
  {
    ssp_mode_t mode;
    logic [SSP_ADDR_W-1:0] base;
    logic [1:0] burst;
    logic lin;
    logic drive;
    logic [SSP_DATA_W-1:0] q;
  } ssp_state_t;
  ssp_state_t st_ff;
  ssp_state_t nxt_st;
  logic [SSP_DATA_W-1:0] mem [SSP_DEPTH];
  logic sleep_sync;
  logic selected;
  logic full_write;
  logic [SSP_LANES-1:0] lane_we;
  logic ads_p;
  logic ads_c;
  logic burst_advance;
  logic start;
  logic [1:0] nxt_lo;
  logic [SSP_ADDR_W-1:0] cur_addr;
  logic [SSP_ADDR_W-1:0] nxt_addr;
  logic do_write;
  // output enable pin after its two flip-flops
  logic oe_sync;
  // a processor-strobe start, which is always a read
  logic proc_only;
  // a start, or an advance inside a live burst
  logic run_cycle;
  // address that a write in this cycle lands on
  logic [SSP_ADDR_W-1:0] wr_addr;
  // ==========================================================
  // sleep request synchroniser
  ssp_sync2 u_sleep_sync
  (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(sleep_request_in),
    .sync_out(sleep_sync)
  );
  // ==========================================================
  // output enable synchroniser
  // the pin comes from outside the clock domain, so it is
  // resynchronised like the sleep request; this adds two cycles
  // of latency between the pin and the data bus enable
  ssp_sync2 u_oe_sync
  (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(output_enable_n_in),
    .sync_out(oe_sync)
  );
  // ==========================================================
  // decode
  // three-input select decode
  assign selected = !select_low_a_in && select_high_in && !select_low_b_in; // RQ2
  // full-width write by either path
  assign full_write = !global_write_n_in ||
                      (!byte_write_gate_n_in && (lane_write_n_in == '0)); // RQ3
  assign ads_p = !proc_addr_strobe_n_in;
  assign ads_c = !ctrl_addr_strobe_n_in;
  assign burst_advance = !burst_advance_n_in;
  // processor strobe cannot start a cycle while select_low_a is high; it idles the burst instead
  assign start = selected && (ads_c || (ads_p && !select_low_a_in));
  // current burst address, following the burst order chosen at start
  assign cur_addr = st_ff.lin ? {st_ff.base[SSP_ADDR_W-1:2], st_ff.base[1:0] + st_ff.burst}
                              : {st_ff.base[SSP_ADDR_W-1:2], st_ff.base[1:0] ^ st_ff.burst};
  // linear burst adds, interleaved burst xors the counter
  always_comb
  begin
    nxt_lo = st_ff.burst + 2'h1;
    nxt_addr = st_ff.lin ? {st_ff.base[SSP_ADDR_W-1:2], st_ff.base[1:0] + nxt_lo}
                         : {st_ff.base[SSP_ADDR_W-1:2], st_ff.base[1:0] ^ nxt_lo};
  end
  // per-lane write enables
  generate
    for (genvar i = 0; i < SSP_LANES; i++)
    begin : g_lane
      assign lane_we[i] = full_write || (!byte_write_gate_n_in && !lane_write_n_in[i]);
    end
  endgenerate
  // a write needs a running cycle and must not be a processor-strobe start
  assign proc_only = start && ads_p && !ads_c;
  // an advance outside a burst or in sleep does not open a cycle
  assign run_cycle = start || (burst_advance && (st_ff.mode != SSP_IDLE) && (st_ff.mode != SSP_SLEEP));
  // writes are blocked while sleep_sync is high so a late enable cannot touch the array
  assign do_write = !sleep_sync && (lane_we != '0) && !proc_only && run_cycle;
  // a start writes its own address, an advance the next burst address
  assign wr_addr = start ? addr_in : (burst_advance ? nxt_addr : cur_addr);
  // ==========================================================
  // next state
  always_comb
  begin
    nxt_st = st_ff;
    if (sleep_sync)
    begin
      // sleep entry assumes host deselected first
      nxt_st.mode = SSP_SLEEP; // RQ5
      nxt_st.drive = 1'b0; // RQ6
    end
    else if (st_ff.mode == SSP_SLEEP)
    begin
      nxt_st.mode = SSP_IDLE;
      nxt_st.drive = 1'b0; // RQ6
    end
    else if (start)
    begin
      // new burst; a write stays high impedance, a read drives
      nxt_st.base = addr_in;
      nxt_st.burst = SSP_BURST_RST;
      nxt_st.lin = !burst_mode_in;
      nxt_st.mode = do_write ? SSP_WRITE : SSP_READ;
      nxt_st.drive = !do_write; // RQ4
      nxt_st.q = mem[addr_in];
    end
    else if (!selected && (ads_p || ads_c))
    begin
      nxt_st.mode = SSP_IDLE;
      nxt_st.drive = 1'b0;
    end
    else if (burst_advance && st_ff.mode != SSP_IDLE)
    begin
      // advance re-enables the data bus for reads
      nxt_st.burst = st_ff.burst + 2'h1;
      nxt_st.mode = do_write ? SSP_WRITE : SSP_READ;
      nxt_st.drive = !do_write; // RQ4
      nxt_st.q = mem[nxt_addr];
    end
    else if (do_write)
    begin
      nxt_st.mode = SSP_WRITE;
      nxt_st.drive = 1'b0; // RQ4
    end
    if (sys_rst_in)
    begin
      nxt_st = '0;
      nxt_st.mode = SSP_IDLE;
      nxt_st.drive = SSP_DRIVE_RST;
    end
  end
  // state register
  always_ff @(posedge clk_in)
  begin
    st_ff <= nxt_st;
  end
  // memory write, one process so the array has a single driver;
  // each lane is written only when its own enable is active
  always_ff @(posedge clk_in)
  begin
    for (int j = 0; j < SSP_LANES; j++)
    begin
      if (do_write && lane_we[j] && !sys_rst_in) // RQ3
      begin
        mem[wr_addr][j*SSP_LANE_W +: SSP_LANE_W] <= data_in[j*SSP_LANE_W +: SSP_LANE_W];
      end
    end
  end
  // ==========================================================
  // outputs
  // output enable pin gates the drive flag; RQ1 is the host's wait
  assign data_out = st_ff.q;
  // synchronised sleep forces the bus released at once
  assign data_oe_n_out = !(st_ff.drive && !oe_sync) || sleep_sync; // RQ6
  assign sleeping_out = (st_ff.mode == SSP_SLEEP);
endmodule : ssp_port

/* File: dv/ssp_port_asserts.sv */
// Purpose: port checks for the sram port
// Assumes: one clock, sync active-high reset
// Notes: bound to ssp_port, names match its ports
module ssp_port_asserts
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // pins watched
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic select_low_a_in,
  input wire logic select_high_in,
  input wire logic select_low_b_in,
  input wire logic global_write_n_in,
  input wire logic output_enable_n_in,
  input wire logic data_oe_n_out,
  input wire logic sleeping_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // controller strobe start, qualified by en
  sequence s_start(en);
    en && proc_addr_strobe_n_in && !ctrl_addr_strobe_n_in;
  endsequence
  // bus released, gate open, no strobe or advance
  sequence s_quiet;
    data_oe_n_out && !output_enable_n_in && proc_addr_strobe_n_in
      && ctrl_addr_strobe_n_in && burst_advance_n_in;
  endsequence
  property p_desel;
    s_start(select_low_a_in || !select_high_in || select_low_b_in) |=> data_oe_n_out;
  endproperty
  a_desel: assert property (p_desel) else $error("bus driven after deselect");
  property p_write;
    s_start(!global_write_n_in) |=> data_oe_n_out;
  endproperty
  a_write: assert property (p_write) else $error("bus driven after write");
  property p_hold;
    s_quiet ##1 !output_enable_n_in |-> data_oe_n_out;
  endproperty
  a_hold: assert property (p_hold) else $error("bus left released state");
  property p_wake;
    $fell(sleeping_out) |-> data_oe_n_out;
  endproperty
  a_wake: assert property (p_wake) else $error("bus driven on wake");
endmodule : ssp_port_asserts
bind ssp_port ssp_port_asserts u_chk (.*);

/* File: dv/ssp_host.sv */
// Purpose: host model driving the sram port pins
// Assumes: pins move just after clk_in rises
// Notes: ctl is {sleep, selects a high b, proc and ctrl strobes, global, gate, lanes}
module ssp_host
(
  // clock
  input wire logic clk_in,
  // pins toward the port
  output logic [9:0] ctl_out = 10'h0BF,
  output logic [ssp_pkg::SSP_ADDR_W-1:0] addr_out = '0,
  output logic [ssp_pkg::SSP_DATA_W-1:0] dat_out = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssp_pkg::*;
  // one bus cycle; data lines carry inverted junk unless writing
  task automatic op(input logic [9:0] c, input logic [SSP_ADDR_W-1:0] a,
    input logic [SSP_DATA_W-1:0] d);
    @(posedge clk_in);
    ctl_out <= c;
    addr_out <= a;
    dat_out <= (c[3:0] == 4'hF) ? ~dat_out : d;
  endtask : op
endmodule : ssp_host

/* File: dv/ssp_port_bench.sv */
// Purpose: self-checking bench for the sram port
// Assumes: 100 MHz clk_in, host model drives the pins
// Notes: power-up wait not modelled, memory starts unknown
module ssp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ssp_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [9:0] ctl;
  logic [SSP_ADDR_W-1:0] addr;
  logic [SSP_DATA_W-1:0] wd, rd;
  logic oe_n, zz;
  int miscompares = 0;
  int num_checks = 0;
  // rows of {ctl, addr, data}: global write, gated write, then reads back
  logic [43:0] rows [4] = '{{10'h0A7, 16'h0001, 18'h2AAAA}, {10'h0A8, 16'hFFFF, 18'h15555},
    {10'h0AF, 16'h0001, 18'h2AAAA}, {10'h0AF, 16'hFFFF, 18'h15555}};
  initial forever #5 clk_in = ~clk_in;
  ssp_host host (.clk_in(clk_in), .ctl_out(ctl), .addr_out(addr), .dat_out(wd));
  ssp_port dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr),
    .proc_addr_strobe_n_in(ctl[5]), .ctrl_addr_strobe_n_in(ctl[4]), .burst_advance_n_in(1'b1),
    .burst_mode_in(1'b0), .select_low_a_in(ctl[8]), .select_high_in(ctl[7]),
    .select_low_b_in(ctl[6]), .global_write_n_in(ctl[3]), .byte_write_gate_n_in(ctl[2]),
    .lane_write_n_in(ctl[1:0]), .output_enable_n_in(1'b0), .sleep_request_in(ctl[9]),
    .data_in(wd), .data_out(rd), .data_oe_n_out(oe_n), .sleeping_out(zz));
  // compare and count
  task automatic chk(input string n, input logic [SSP_DATA_W-1:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // ==========================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1;
    chk("reset oe_n", 18'h1, 18'(oe_n));
    foreach (rows[i])
    begin
      host.op(rows[i][43:34], rows[i][33:18], rows[i][17:0]);
      host.op(10'h0BF, '0, '0);
      #1;
      chk("row oe_n", 18'(rows[i][43:34] != 10'h0AF), 18'(oe_n));
      chk("row data", (rows[i][43:34] == 10'h0AF) ? rows[i][17:0] : rd, rd);
    end
    host.op(10'h0A7, 16'h0002, 18'h3FFFF);
    host.op(10'h09F, 16'h0002, '0);
    host.op(10'h0BF, '0, '0);
    #1;
    chk("proc read", 18'h3FFFF, rd);
    chk("proc oe_n", 18'h0, 18'(oe_n));
    $display("test rows done");
    for (int s = 0; s < 8; s++)
    begin
      host.op(10'h0AF, 16'h0001, '0);
      host.op({1'b0, 3'(s), 6'h2F}, 16'h0001, '0);
      host.op(10'h0BF, '0, '0);
      #1;
      chk("select oe_n", 18'(s != 2), 18'(oe_n));
    end
    $display("test selects done");
    host.op(10'h1AF, '0, '0);
    host.op(10'h3AF, '0, '0);
    repeat (4) @(negedge clk_in);
    chk("asleep", 18'h1, 18'(zz));
    host.op(10'h1AF, '0, '0);
    repeat (4) @(negedge clk_in);
    chk("awake", 18'h0, 18'(zz));
    chk("wake oe_n", 18'h1, 18'(oe_n));
    $display("test sleep done");
    stop_test();
  end
  // watchdog, far past the fifty cycles the tests take
  initial
  begin
    repeat (500) @(posedge clk_in);
    miscompares++;
    stop_test();
  end
endmodule : ssp_port_bench
